// *** rtl/luma_post.sv ***
// Module: luma post-processing - noise reduction, gamma curves,
// average brightness monitor and output clock pin control.
// Assumes: register port driven by the serial-port decoder on mclk;
// pixel stream from on-chip logic on mclk; vsync_n_pin is asynchronous.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Three-bit select picks filter; only its passband content is noise-processed.
// - Mode bit 0 gives noise reduction, 1 gives sharpness mode.
// - Noise mode: filtered part below threshold, scaled by gain, subtracted.
// - Sharpness mode: filtered part above threshold, scaled by gain, added.
// - Four-bit offset shifts block against coring-gain positions, up to 15 pixels.
// - Fourteen 8-bit gamma registers from 26H hold curves A and B.
// - Gamma acts on luma only; exactly one curve in use.
// - Curve points programmable at inputs 32,64,...,224 over 256 inputs.
// - Inputs between curve points are linearly interpolated.
// - Points 0, 16, 240, 255 fixed; user curves valid within 16..240.
// - Read-only 34H reports per-field average brightness.
// - Brightness averages active-video luma only, blanking excluded.
// - Brightness result updates on each falling vertical sync edge.
// - Clock enable bit set drives output pin with the 54 MHz clock.
// - Clock output only while PLL enabled and oversampling enabled.
// - Threshold is six-bit absolute value 0..63 in companion register.
// - Noise mode coring gain spans 0..1 in eighths.
// - Sharpness mode coring gain spans 0..0.5 in sixteenths.
// - One pixel equals two sample clock cycles for block position.
module luma_post #(
	parameter int FIFO_DEPTH = luma_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// Register port
	input  wire logic [5:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	output var  logic       reg_rvalid,
	// Pixel input
	input  wire logic [7:0] pix_y,
	input  wire logic       pix_sol,
	input  wire logic       pix_active,
	input  wire logic       pix_valid,
	output var  logic       pix_ready,
	// Pins and mode bits
	input  wire logic       vsync_n_pin,
	input  wire logic       pll_disable_bit,
	input  wire logic       oversample_enable_bit,
	input  wire logic       gamma_curve_b,
	output var  logic       clk_out_oe_n,
	// Luma output
	output var  logic [7:0] y_out,
	output var  logic       y_out_valid,
	input  wire logic       y_out_ready
);
	if (FIFO_DEPTH < 2) begin : g_chk
		$error("luma_post: FIFO_DEPTH must be at least 2");
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0]                   nr2;
		logic [7:0]                   nr1;
		logic [7:0]                   nr0;
		logic [7:0]                   output_clock_control;
		logic [13:0][7:0]             gam;
		logic [7:0]                   bright;
		logic [7:0]                   rdata;
		logic                         rvalid;
		logic [2:0]                   vs_sync;
		logic                         vs_lvl;
		logic [7:0][7:0]              hist;
		logic [3:0]                   pix;
		logic                         phase;
		logic [luma_pkg::SUM_W-1:0]   sum;
		logic [luma_pkg::CNT_W-1:0]   cnt;
		logic                         s1_v;
		logic [7:0]                   s1_y;
		logic                         o_v;
		logic [7:0]                   o_y;
		logic                         clk_oe_n;
	} post_state_t;

	post_state_t st_r;
	post_state_t st_nxt;

	fifo_if #(.W(luma_pkg::FIFO_W)) fif ();

	sample_fifo #(
		.W     (luma_pkg::FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk (mclk),
		.nrst (nrst),
		.f    (fif.store)
	);

	assign fif.push_valid = pix_valid;
	assign fif.push_data  = {pix_active, pix_sol, pix_y};
	assign pix_ready      = fif.push_ready;
	assign reg_rdata      = st_r.rdata;
	assign reg_rvalid     = st_r.rvalid;
	assign clk_out_oe_n   = st_r.clk_oe_n;
	assign y_out          = st_r.o_y;
	assign y_out_valid    = st_r.o_v;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	function automatic logic is_gamma(input logic [5:0] a);
		return a >= luma_pkg::ADDR_GAMMA0 &&
		       a < 6'(luma_pkg::ADDR_GAMMA0 + 6'(luma_pkg::GAMMA_REGS));
	endfunction : is_gamma

	function automatic logic [7:0] gamma_map(input logic [7:0] x,
	                                         input logic [6:0][7:0] p);
		logic [7:0]  lo;
		logic [7:0]  hi;
		logic [5:0]  span;
		logic [5:0]  t;
		logic [14:0] acc;
		logic [9:0]  q;
		lo   = p[0];
		hi   = p[0];
		span = 6'h20;
		t    = 6'h00;
		if (x < luma_pkg::FIX_LO || x >= luma_pkg::FIX_HI)
			return x;
		if (x < 8'h20) begin
			lo   = luma_pkg::FIX_LO;
			hi   = p[0];
			span = 6'h10;
			t    = 6'(x - luma_pkg::FIX_LO);
		end else if (x >= 8'he0) begin
			lo   = p[6];
			hi   = luma_pkg::FIX_HI;
			span = 6'h10;
			t    = 6'(x - 8'he0);
		end else begin
			lo = p[3'(x[7:5] - 3'h1)];
			hi = p[x[7:5]];
			t  = {1'b0, x[4:0]};
		end
		// Weighted sum with half-span added rounds to nearest
		acc = 15'(lo) * 15'(span - t) + 15'(hi) * 15'(t) +
		      15'(span >> 1);
		q   = (span == 6'h10) ? 10'(acc >> 4) : 10'(acc >> 5);
		return (q > 10'h0ff) ? 8'hff : q[7:0];
	endfunction : gamma_map

	function automatic logic [7:0] average(
		input logic [luma_pkg::SUM_W-1:0] s,
		input logic [luma_pkg::CNT_W-1:0] c);
		logic [luma_pkg::SUM_W-1:0] rem;
		logic [luma_pkg::SUM_W-1:0] trial;
		logic [7:0]                 q;
		rem = s;
		q   = 8'h00;
		if (c == '0)
			return 8'h00;
		for (int i = 7; i >= 0; i--) begin
			trial = luma_pkg::SUM_W'({8'h00, c} << i);
			if (rem >= trial) begin
				rem  = rem - trial;
				q[i] = 1'b1;
			end
		end
		return q;
	endfunction : average

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	logic               adv;
	logic               take;
	logic               w_act;
	logic               w_sol;
	logic [7:0]         w_y;
	logic               vs_fall;
	logic               mode_sharp;
	logic [5:0]         thr;
	logic signed [8:0]  nr_f;
	logic [7:0]         nr_abs;
	logic               nr_core;
	logic [3:0]         cur_pix;
	logic [3:0]         bpos;
	logic [4:0]         bsize;
	logic [3:0]         bwid;
	logic               border;
	logic [3:0]         graw;
	logic [4:0]         gain;
	logic signed [14:0] prod;
	logic signed [14:0] delta;
	logic signed [14:0] res;
	logic [7:0]         nr_y;
	logic [3:0]         gidx;

	assign {w_act, w_sol, w_y} = fif.pop_data;
	assign mode_sharp = st_r.nr2[luma_pkg::NR2_MODE_BIT];
	assign thr = st_r.nr1[luma_pkg::NR1_THR_LSB +: 6];
	assign fif.pop_ready = adv;

	always_comb begin
		st_nxt = st_r;
		adv    = !st_r.o_v || y_out_ready;
		take   = adv && fif.pop_valid;
		gidx   = 4'(reg_addr - luma_pkg::ADDR_GAMMA0);

		// Vertical sync: three flops, level moves when last two agree
		st_nxt.vs_sync = {st_r.vs_sync[1:0], vsync_n_pin};
		if (st_r.vs_sync[1] == st_r.vs_sync[2])
			st_nxt.vs_lvl = st_r.vs_sync[2];
		vs_fall = st_r.vs_lvl && (st_r.vs_sync[2:1] == 2'b00);

		// Filter: difference to a delayed sample, longer delay = lower band
		nr_f   = 9'sh000;
		nr_f   = 9'($signed({1'b0, w_y}) -
		            $signed({1'b0, st_r.hist[st_r.nr2[2:0]]})) >>> 1;
		nr_abs = nr_f[8] ? 8'(-nr_f) : nr_f[7:0];

		// Block position with pixel = CYC_PER_PIXEL samples
		cur_pix = w_sol ? 4'h0 : st_r.pix;
		bpos    = 4'(cur_pix + st_r.nr2[luma_pkg::NR2_OFFS_LSB +: 4]);
		bsize   = st_r.nr1[luma_pkg::NR1_BSIZE_BIT] ?
		          luma_pkg::BLOCK_LARGE : luma_pkg::BLOCK_SMALL;
		if (!st_r.nr1[luma_pkg::NR1_BSIZE_BIT])
			bpos = {1'b0, bpos[2:0]};
		bwid    = st_r.nr1[luma_pkg::NR1_BORDER_BIT] ?
		          luma_pkg::BORDER_WIDE : luma_pkg::BORDER_NARROW;
		border  = (bpos < bwid) || ({1'b0, bpos} >= 5'(bsize - {1'b0, bwid}));
		graw    = border ? st_r.nr0[luma_pkg::NR0_GBORD_LSB +: 4] :
		                   st_r.nr0[luma_pkg::NR0_GDATA_LSB +: 4];
		// Codes past the top of the range saturate at full scale
		gain    = ({1'b0, graw} > luma_pkg::GAIN_MAX) ?
		          luma_pkg::GAIN_MAX : {1'b0, graw};
		prod    = 15'(nr_f) * 15'($signed({1'b0, gain}));
		nr_core = mode_sharp ? (nr_abs > {2'b00, thr}) :
		                       (nr_abs < {2'b00, thr});
		delta   = mode_sharp ? ((prod + 15'sh0008) >>> 4) :
		                       ((prod + 15'sh0004) >>> 3);
		res     = 15'($signed({1'b0, w_y}));
		if (nr_core)
			res = mode_sharp ? res + delta :
			                   res - delta;
		nr_y    = (res < 0) ? 8'h00 : (res > 15'sh00ff) ? 8'hff : res[7:0];

		// Pipeline
		if (adv) begin
			st_nxt.o_v = st_r.s1_v;
			st_nxt.o_y = gamma_b_sel(st_r.s1_y);
			st_nxt.s1_v = take;
			if (take)
				st_nxt.s1_y = nr_y;
		end
		if (take) begin
			st_nxt.hist  = {st_r.hist[6:0], w_y};
			st_nxt.phase = w_sol ? 1'b1 :
			               (st_r.phase == 1'(luma_pkg::CYC_PER_PIXEL - 1)) ?
			               1'b0 : 1'b1;
			if (w_sol)
				st_nxt.pix = 4'h0;
			else if (st_r.phase)
				st_nxt.pix = 4'(st_r.pix + 4'h1);
		end

		// Brightness accumulation over active samples only
		if (vs_fall) begin
			st_nxt.bright = average(st_r.sum, st_r.cnt);
			st_nxt.sum    = '0;
			st_nxt.cnt    = '0;
		end
		if (take && w_act) begin
			st_nxt.sum = luma_pkg::SUM_W'(st_nxt.sum + w_y);
			st_nxt.cnt = luma_pkg::CNT_W'(st_nxt.cnt + 1'b1);
		end

		// Register writes
		if (reg_wr) begin
			if (reg_addr == luma_pkg::ADDR_NR2)
				st_nxt.nr2 = reg_wdata;
			if (reg_addr == luma_pkg::ADDR_NR1)
				st_nxt.nr1 = reg_wdata;
			if (reg_addr == luma_pkg::ADDR_NR0)
				st_nxt.nr0 = reg_wdata;
			if (reg_addr == luma_pkg::ADDR_OCR)
				st_nxt.output_clock_control = reg_wdata;
			if (is_gamma(reg_addr))
				st_nxt.gam[gidx] = reg_wdata;
		end

		// Register reads, unmapped addresses read zero
		st_nxt.rvalid = reg_rd;
		if (reg_rd) begin
			st_nxt.rdata = 8'h00;
			if (reg_addr == luma_pkg::ADDR_NR2)
				st_nxt.rdata = st_r.nr2;
			if (reg_addr == luma_pkg::ADDR_NR1)
				st_nxt.rdata = st_r.nr1;
			if (reg_addr == luma_pkg::ADDR_NR0)
				st_nxt.rdata = st_r.nr0;
			if (reg_addr == luma_pkg::ADDR_OCR)
				st_nxt.rdata = st_r.output_clock_control;
			if (reg_addr == luma_pkg::ADDR_BRIGHT)
				st_nxt.rdata = st_r.bright;
			if (is_gamma(reg_addr))
				st_nxt.rdata = st_r.gam[gidx];
		end

		// Clock pin driven only with PLL and oversampling running
		st_nxt.clk_oe_n = !(st_r.output_clock_control[luma_pkg::OCR_CLK_OUT_PIN_BIT] &&
		                    !pll_disable_bit &&
		                    oversample_enable_bit);

		if (!nrst) begin
			st_nxt        = '0;
			st_nxt.nr2    = luma_pkg::NR_RESET;
			st_nxt.nr1    = luma_pkg::NR_RESET;
			st_nxt.nr0    = luma_pkg::NR_RESET;
			st_nxt.output_clock_control    = luma_pkg::OCR_RESET;
			st_nxt.vs_sync  = 3'h7;
			st_nxt.vs_lvl   = 1'b1;
			st_nxt.clk_oe_n = 1'b1;
			for (int i = 0; i < luma_pkg::GAMMA_REGS; i++)
				st_nxt.gam[i] = 8'(luma_pkg::GAMMA_STEP * 8'(i % 7 + 1));
		end
	end

	// Curve choice kept in one place; each curve has its own gamma_map call, result muxed
	function automatic logic [7:0] gamma_b_sel(input logic [7:0] x);
		return gamma_curve_b ? gamma_map(x, st_r.gam[13:7]) :
		                       gamma_map(x, st_r.gam[6:0]);
	endfunction : gamma_b_sel

	always_ff @(posedge mclk) begin
		st_r <= st_nxt;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	nr_pass_a: assert property (
		!mode_sharp && (nr_abs >= {2'b00, thr}) |-> nr_y == w_y)
		else $error("noise mode altered sample above threshold");
	sharp_pass_a: assert property (
		mode_sharp && (nr_abs <= {2'b00, thr}) |-> nr_y == w_y)
		else $error("sharp mode altered sample within threshold");
	nr_gain_a: assert property (
		!mode_sharp && nr_core && nr_f >= 0 |-> nr_y <= w_y)
		else $error("noise mode added instead of subtracting");
	bright_upd_a: assert property (
		st_r.bright != $past(st_r.bright) |-> $past(vs_fall))
		else $error("brightness changed without vsync fall");
	bright_active_a: assert property (
		take && !w_act && !vs_fall |=> $stable(st_r.cnt))
		else $error("blanking sample counted");
	gamma_fixed_a: assert property (
		adv && st_r.s1_v && st_r.s1_y < luma_pkg::FIX_LO
		|=> y_out == $past(st_r.s1_y))
		else $error("fixed low segment not identity");
	gamma_point_a: assert property (
		adv && st_r.s1_v && st_r.s1_y == 8'h20 && !gamma_curve_b
		|=> y_out == $past(st_r.gam[0]))
		else $error("curve A first point not honoured");
	clk_out_pin_a: assert property (
		!clk_out_oe_n |-> $past(!pll_disable_bit && oversample_enable_bit))
		else $error("clock pin driven with PLL or oversampling off");
	rdata_a: assert property (
		reg_rd && reg_addr == luma_pkg::ADDR_BRIGHT
		|=> reg_rvalid && reg_rdata == $past(st_r.bright))
		else $error("brightness readback wrong");

	sharp_c: cover property (take && mode_sharp && nr_core);
	vs_c:    cover property (vs_fall && st_r.cnt != '0);
	stall_c: cover property (st_r.o_v && !y_out_ready && fif.pop_valid);
endmodule : luma_post
`default_nettype wire

// *** rtl/luma_pkg.sv ***
// Package: register map, field layout, reset values and sizes of the luma
// post-processing block.
// Assumes: used by rtl/luma_post.sv only; rtl/sample_fifo.sv takes its sizes as parameters.
package luma_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [5:0] ADDR_NR2    = 6'h23;
	localparam logic [5:0] ADDR_NR1    = 6'h24;
	localparam logic [5:0] ADDR_NR0    = 6'h25;
	localparam logic [5:0] ADDR_GAMMA0 = 6'h26;
	localparam logic [5:0] ADDR_BRIGHT = 6'h34;
	localparam logic [5:0] ADDR_OCR    = 6'h35;
	localparam int         GAMMA_REGS  = 14;
	localparam int         GAMMA_PTS   = 7;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int NR2_FSEL_LSB   = 0;
	localparam int NR2_MODE_BIT   = 3;
	localparam int NR2_OFFS_LSB   = 4;
	localparam int NR1_THR_LSB    = 0;
	localparam int NR1_BORDER_BIT = 6;
	localparam int NR1_BSIZE_BIT  = 7;
	localparam int NR0_GBORD_LSB  = 0;
	localparam int NR0_GDATA_LSB  = 4;
	localparam int OCR_CLK_OUT_PIN_BIT = 1;

	// ------------------------------------------------------------------
	// Reset values and fixed numbers
	// ------------------------------------------------------------------
	localparam logic [7:0] NR_RESET    = 8'h00;
	localparam logic [7:0] OCR_RESET   = 8'h70;
	localparam logic [7:0] GAMMA_STEP  = 8'h20;
	localparam logic [7:0] FIX_LO      = 8'h10;
	localparam logic [7:0] FIX_HI      = 8'hf0;
	localparam logic [4:0] GAIN_MAX    = 5'h08;
	localparam logic [3:0] BORDER_NARROW = 4'h2;
	localparam logic [3:0] BORDER_WIDE   = 4'h4;
	localparam logic [4:0] BLOCK_SMALL   = 5'h08;
	localparam logic [4:0] BLOCK_LARGE   = 5'h10;
	localparam int         CYC_PER_PIXEL = 2;
	localparam int         SUM_W         = 28;
	localparam int         CNT_W         = 20;
	localparam int         FIFO_DEPTH    = 32;
	localparam int         FIFO_W        = 10;

endpackage : luma_pkg

// *** rtl/fifo_if.sv ***
// Interface: sample path between the luma block and its input FIFO.
// Assumes: one pusher/popper (luma_post) and one store (sample_fifo).
`timescale 1ns/100ps
`default_nettype none
interface fifo_if #(parameter int W = 10) ();
	logic         push_valid;
	logic         push_ready;
	logic [W-1:0] push_data;
	logic         pop_valid;
	logic         pop_ready;
	logic [W-1:0] pop_data;

	modport store (input push_valid, push_data, pop_ready,
	               output push_ready, pop_valid, pop_data);
	modport user  (output push_valid, push_data, pop_ready,
	               input push_ready, pop_valid, pop_data);
endinterface : fifo_if
`default_nettype wire

// *** rtl/sample_fifo.sv ***
// Module: flip-flop FIFO with valid/ready on both sides.
// Assumes: single clock mclk, synchronous active-low reset nrst.
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
	parameter int W     = 10,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Sample path
	fifo_if.store    f
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("sample_fifo: DEPTH must be a power of two, at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           rd;
		logic [AW-1:0]           wr;
		logic [AW:0]             cnt;
		logic                    ready;
		logic                    valid;
	} fifo_state_t;

	fifo_state_t st_r;
	fifo_state_t st_nxt;
	logic        push;
	logic        pop;

	assign f.push_ready = st_r.ready;
	assign f.pop_valid  = st_r.valid;
	assign f.pop_data   = st_r.mem[st_r.rd];

	always_comb begin
		st_nxt = st_r;
		push   = f.push_valid && st_r.ready;
		pop    = f.pop_ready && st_r.valid;
		if (push) begin
			st_nxt.mem[st_r.wr] = f.push_data;
			st_nxt.wr           = AW'(st_r.wr + 1'b1);
		end
		if (pop)
			st_nxt.rd = AW'(st_r.rd + 1'b1);
		st_nxt.cnt   = (AW+1)'(st_r.cnt + {AW'(0), push} - {AW'(0), pop});
		st_nxt.ready = st_nxt.cnt != (AW+1)'(DEPTH);
		st_nxt.valid = st_nxt.cnt != '0;
		if (!nrst) begin
			st_nxt.rd    = '0;
			st_nxt.wr    = '0;
			st_nxt.cnt   = '0;
			st_nxt.ready = 1'b0;
			st_nxt.valid = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		st_r <= st_nxt;
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	fifo_bound_a: assert property (@(posedge mclk) disable iff (!nrst)
		st_r.cnt <= (AW+1)'(DEPTH))
		else $error("fifo count beyond depth");
	fifo_full_c: cover property (@(posedge mclk) disable iff (!nrst)
		!st_r.ready);
endmodule : sample_fifo
`default_nettype wire

// *** sim/pix_src.sv ***
// Partner model: video source offering luma samples to the block.
// Assumes: shares mclk and nrst; samples are queued by the bench.
`timescale 1ns/100ps
`default_nettype none
module pix_src (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// Sample stream
	output var  logic [7:0] pix_y,
	output var  logic       pix_sol,
	output var  logic       pix_active,
	output var  logic       pix_valid,
	input  wire logic       pix_ready
);
	logic [9:0] q[$];
	logic       slow = 1'b0;
	task automatic send(input logic [7:0] y, input logic a, s);
		q.push_back({s, a, y});
	endtask : send
	// Held until taken; idle data toggles so a stale value never matches
	always @(posedge mclk) begin
		if (!nrst) begin
			{pix_valid, pix_sol, pix_active, pix_y} <= 11'h000;
		end else if (!pix_valid || pix_ready) begin
			if (q.size() > 0 && !(slow && pix_valid)) begin
				{pix_sol, pix_active, pix_y} <= q.pop_front();
				pix_valid <= 1'b1;
			end else begin
				pix_valid <= 1'b0;
				pix_y     <= ~pix_y;
			end
		end
	end
endmodule : pix_src
`default_nettype wire

// *** sim/tb.sv ***
// Bench: register accesses and pixel runs through luma_post.
// Assumes: pix_src partner model; default FIFO depth of 32.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic       mclk = 1'b0;
	logic       nrst = 1'b0;
	logic [5:0] reg_addr = 6'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic       reg_rvalid;
	logic [7:0] pix_y;
	logic       pix_sol, pix_active, pix_valid, pix_ready;
	logic       vsync_n_pin = 1'b1;
	logic       pll_disable_bit = 1'b0;
	logic       oversample_enable_bit = 1'b1;
	logic       gamma_curve_b = 1'b0;
	logic       clk_out_oe_n;
	logic [7:0] y_out;
	logic       y_out_valid;
	logic       y_out_ready = 1'b1;
	logic [8:0] exp_q[$];
	logic [8:0] e;
	logic [7:0] gi[7] = '{8'd8, 8'd100, 8'd124, 8'd128, 8'd144, 8'd250, 8'd20};
	logic [7:0] go[7] = '{8'd8, 8'd100, 8'd126, 8'd130, 8'd145, 8'd250, 8'd20};
	int         n_fail = 0;
	int         check_count = 0;
	int         i;

	initial forever #12.5 mclk = ~mclk;

	pix_src pix_src_inst (.mclk(mclk), .nrst(nrst), .pix_y(pix_y),
		.pix_sol(pix_sol), .pix_active(pix_active),
		.pix_valid(pix_valid), .pix_ready(pix_ready));
	luma_post luma_post_inst (.mclk(mclk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.pix_y(pix_y), .pix_sol(pix_sol), .pix_active(pix_active),
		.pix_valid(pix_valid), .pix_ready(pix_ready),
		.vsync_n_pin(vsync_n_pin), .pll_disable_bit(pll_disable_bit),
		.oversample_enable_bit(oversample_enable_bit),
		.gamma_curve_b(gamma_curve_b), .clk_out_oe_n(clk_out_oe_n),
		.y_out(y_out), .y_out_valid(y_out_valid),
		.y_out_ready(y_out_ready));

	task automatic chk(input string nm, input logic [7:0] x, g);
		check_count++;
		if (g !== x) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [7:0] x);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rvalid", 8'h01, {7'h00, reg_rvalid});
		chk("reg_rdata", x, reg_rdata);
	endtask : rd
	task automatic px(input logic [7:0] y, input logic a, s,
		input logic [8:0] x);
		pix_src_inst.send(y, a, s);
		exp_q.push_back(x);
	endtask : px
	// Bounded wait until every queued sample has left the block
	task automatic drain();
		int k;
		for (k = 0; k < 3000 && exp_q.size() > 0; k++) @(posedge mclk);
		if (exp_q.size() > 0) begin
			n_fail++;
			print_verdict();
		end else begin
			repeat (4) @(posedge mclk);
		end
	endtask : drain
	task automatic vfall();
		@(posedge mclk);
		vsync_n_pin <= 1'b0;
		repeat (6) @(posedge mclk);
		vsync_n_pin <= 1'b1;
		repeat (4) @(posedge mclk);
	endtask : vfall
	// Step 100 to 110; samples right after the step see the filter
	task automatic nr_run(input logic [2:0] sel, input logic md,
		input logic [5:0] thr, input logic [7:0] alt);
		int k;
		logic [8:0] x;
		wr(6'h23, {sel, 1'b1, md, sel});
		wr(6'h24, {2'b00, thr});
		for (k = 0; k < 20; k++) begin
			x = (k <= sel) ? 9'h100 : (k < 10) ? 9'd100 :
			    (k <= 10 + sel) ? {1'b0, alt} : 9'd110;
			px((k < 10) ? 8'd100 : 8'd110, 1'b1, k == 0, x);
		end
		drain();
	endtask : nr_run
	// One line of 16 samples, two per pixel, 8-pixel blocks, 2-pixel borders;
	// border gain 0 leaves the sample, data gain 8 cores the 100/110 swing
	task automatic blk_run(input logic [3:0] offs);
		int k;
		logic [2:0] b;
		wr(6'h23, {offs, 4'h0});
		for (k = 0; k < 16; k++) begin
			b = 3'(k / 2 + offs);
			px(k[0] ? 8'h6e : 8'h64, 1'b1, k == 0,
			   (k == 0) ? 9'h100 : (b < 3'h2 || b >= 3'h6) ?
			   (k[0] ? 9'h06e : 9'h064) : 9'h069);
		end
		drain();
	endtask : blk_run

	// Sink: skip marks cover samples whose history is not modelled
	always @(posedge mclk) begin
		if (nrst && y_out_valid && y_out_ready) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h0aa;
			if (!e[8]) chk("y_out", e[7:0], y_out);
		end
	end

	initial begin
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		for (i = 0; i < 3; i++) rd(6'(6'h23 + i), 8'h00);
		rd(6'h35, 8'h70);
		rd(6'h34, 8'h00);
		for (i = 0; i < 14; i++) rd(6'(6'h26 + i), 8'(32 * (i % 7 + 1)));
		rd(6'h3f, 8'h00);
		wr(6'h34, 8'hff);
		rd(6'h34, 8'h00);
		wr(6'h35, 8'h72);
		rd(6'h35, 8'h72);
		for (i = 0; i < 4; i++) begin
			@(posedge mclk);
			{pll_disable_bit, oversample_enable_bit} <= 2'(i);
			repeat (2) @(posedge mclk);
			#1;
			chk("clk_out_oe_n", {7'h00, i != 1}, {7'h00, clk_out_oe_n});
		end
		@(posedge mclk);
		{pll_disable_bit, oversample_enable_bit} <= 2'b01;
		wr(6'h35, 8'h70);
		repeat (3) @(posedge mclk);
		#1;
		chk("clk_out_oe_n", 8'h01, {7'h00, clk_out_oe_n});
		wr(6'h29, 8'h82);
		pix_src_inst.slow <= 1'b1;
		for (i = 0; i < 7; i++) px(gi[i], 1'b1, 1'b0, {1'b0, go[i]});
		px(8'h20, 1'b1, 1'b0, 9'h020);
		drain();
		gamma_curve_b <= 1'b1;
		px(8'd124, 1'b1, 1'b0, 9'd124);
		drain();
		pix_src_inst.slow <= 1'b0;
		wr(6'h25, 8'h88);
		for (i = 0; i < 16; i++) nr_run(i[2:0], i[3], i[3] ? 6'd0 : 6'd63, i[3] ? 8'd113 : 8'd105);
		nr_run(3'd0, 1'b0, 6'd5, 8'd110);
		wr(6'h25, 8'h80);
		wr(6'h24, 8'h3f);
		blk_run(4'h0);
		blk_run(4'h2);
		wr(6'h24, 8'h00);
		wr(6'h23, 8'h00);
		vfall();
		for (i = 0; i < 4; i++) px(8'(10 * i + 10 + i / 3), 1'b1, 1'b0, 9'(10 * i + 10 + i / 3));
		for (i = 0; i < 3; i++) px(8'd200, 1'b0, 1'b0, 9'd200);
		drain();
		vfall();
		rd(6'h34, 8'd25);
		@(posedge mclk);
		y_out_ready <= 1'b0;
		for (i = 0; i < 40; i++) px(8'(50 + i), 1'b1, 1'b0, 9'(50 + i));
		repeat (60) @(posedge mclk);
		#1;
		chk("pix_ready", 8'h00, {7'h00, pix_ready});
		@(posedge mclk);
		y_out_ready <= 1'b1;
		drain();
		print_verdict();
	end
endmodule : tb
`default_nettype wire
